/* design/fpex_unit.v */
// Floating-point exception signalling: pending flags, error output, vectors,
// and state image control for the save and restore instructions.
// Assumes the core presents one instruction per op_valid pulse and accepts
// the one-cycle outcome on res_valid; registers sit on a plain strobe port.
//
// Functional notes
// - Device-unavailable fault wins over a pending numeric exception, which stays pending.
// - A pending exception at the start of a no-wait legacy save pulses the error output.
// - Legacy restore reloads pending flags, so the next instruction raises the exception.
// - Legacy image is 94 bytes in 16-bit mode, 108 bytes in 32-bit mode.
// - Extended image is 512 bytes holding floating-point and SIMD state.
// - Extended image must be 16-byte aligned; otherwise an exception is raised.
// - Extended image uses a different tag format and field lengths.
// - Legacy save reinitialises the unit; extended save leaves it unchanged.
// - An unmasked exception is recorded and drives the error line active.
// - Error is taken before the next waiting or floating instruction, vector 16.
// - No-wait instructions run without the exception; it stays pending, except that the no-wait save clears it.
// - Native error mode bit, control bit 5, selects internal native reporting.
// - Native mode raises vector 16 internally before the next waiting instruction.
// - The error output follows unmasked exceptions whatever the native mode bit.
// - In native mode no no-wait instruction, including the save, raises vector 16.
// - Native reporting uses no external delay; the vector is raised in-line.
// - Multiprocessor configurations report floating exceptions only in native mode.
// - With the task-switched flag set, any instruction but the wait op faults first.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "fpex_defines.vh"
module fpex_unit (
  input wire core_clk,
  input wire rst_n,
  input wire multi_proc,
  input wire op_valid,
  input wire [2:0] op,
  input wire op32,
  input wire [31:0] op_addr,
  input wire [5:0] exc_flags,
  input wire exc_valid,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg fpu_error_output,
  output reg res_valid,
  output reg [1:0] res_code,
  output reg [7:0] res_vector,
  output reg [9:0] img_size,
  output reg img_ext_format,
  output reg fpu_reinit,
  output reg native_mode
);
  reg [7:0] control_register_zero;
  reg [5:0] exc_mask;
  reg [1:0] last_cause;
  reg [9:0] last_size;
  reg [5:0] next_set;
  reg next_clear_all;
  reg next_load_en;
  reg [1:0] next_code;
  reg [7:0] next_vector;
  reg next_reinit;
  reg next_nowait_pulse;
  wire [5:0] pend_flags;
  wire [9:0] calc_size;
  wire calc_misaligned;
  wire calc_legacy;
  wire calc_ext;
  wire task_switched_flag;
  wire native_error_mode_bit;
  wire unmasked_pending;
  wire waiting_op;
  wire sw_clear_en;

  assign task_switched_flag = control_register_zero[`FPEX_CTRL_TASKSW_BIT];
  assign native_error_mode_bit = control_register_zero[`FPEX_CTRL_NATIVE_BIT] | multi_proc;
  assign unmasked_pending = |(pend_flags & ~exc_mask);
  // No-wait forms are the plain no-wait op and the no-wait legacy save.
  assign waiting_op = (op != `FPEX_OP_NOWAIT) && (op != `FPEX_OP_NWSAVE);
  assign sw_clear_en = reg_wr && (reg_addr == `FPEX_ADDR_STATUS);

  // Image size and alignment for the current instruction.
  fpex_image_calc u_calc (
    .op(op),
    .op32(op32),
    .addr(op_addr),
    .size(calc_size),
    .misaligned(calc_misaligned),
    .is_legacy_img(calc_legacy),
    .is_ext_img(calc_ext)
  );

  // Pending flag storage; legacy restore reloads flags from the image word.
  fpex_pending u_pend (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_flags(next_set),
    .clear_all(next_clear_all),
    .load_en(next_load_en),
    .load_flags(op_addr[31:26]),
    .sw_clear_en(sw_clear_en),
    .sw_clear(reg_wdata[5:0]),
    .flags(pend_flags)
  );

  // Instruction outcome decision, evaluated when the core issues one.
  always @* begin
    next_set = exc_valid ? exc_flags : 6'h00;
    next_clear_all = 1'b0;
    next_load_en = 1'b0;
    next_code = `FPEX_RES_DONE;
    next_vector = 8'h00;
    next_reinit = 1'b0;
    next_nowait_pulse = 1'b0;
    if (op_valid) begin
      if (task_switched_flag && op != `FPEX_OP_WAIT) begin
        next_code = `FPEX_RES_UNAVAIL;
        next_vector = `FPEX_VEC_UNAVAIL;
      end else if (unmasked_pending && waiting_op) begin
        next_code = `FPEX_RES_NUMERIC;
        next_vector = `FPEX_VEC_NUMERIC;
      end else if (calc_ext && calc_misaligned) begin
        next_code = `FPEX_RES_ALIGN;
        next_vector = `FPEX_VEC_GP;
      end else begin
        next_code = `FPEX_RES_DONE;
        case (op)
          `FPEX_OP_NWSAVE: begin
            next_nowait_pulse = unmasked_pending;
            next_reinit = 1'b1;
            next_clear_all = 1'b1;
          end
          `FPEX_OP_SAVE: begin
            next_reinit = 1'b1;
            next_clear_all = 1'b1;
          end
          `FPEX_OP_RESTORE: begin
            // pending flags reload from the image.
            next_load_en = 1'b1;
          end
          default: begin
            // extended save leaves the unit unchanged.
            next_reinit = 1'b0;
          end
        endcase
      end
    end
  end

  // Result and image outputs, one-cycle pulse per issued instruction.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_code <= `FPEX_RES_DONE;
      res_vector <= 8'h00;
      img_size <= 10'h000;
      img_ext_format <= 1'b0;
      fpu_reinit <= 1'b0;
      last_cause <= `FPEX_RES_DONE;
      last_size <= 10'h000;
    end else begin
      res_valid <= op_valid;
      res_code <= next_code;
      res_vector <= next_vector;
      img_size <= op_valid ? calc_size : 10'h000;
      // extended tag format flag for the image writer.
      img_ext_format <= op_valid & calc_ext;
      fpu_reinit <= next_reinit;
      if (op_valid) begin
        last_cause <= next_code;
        // Image size is kept so software can read it after the one-cycle pulse.
        last_size <= calc_size;
      end
    end
  end

  // Error output: level while unmasked, plus pulse on no-wait save.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fpu_error_output <= 1'b0;
    end else begin
      fpu_error_output <= unmasked_pending | next_nowait_pulse | (|(next_set & ~exc_mask));
    end
  end

  // Register writes: control word and exception mask.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      control_register_zero <= `FPEX_CTRL_RESET;
      exc_mask <= `FPEX_MASK_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        // native mode selected by bit 5.
        `FPEX_ADDR_CTRL: control_register_zero <= reg_wdata;
        `FPEX_ADDR_MASK: exc_mask <= reg_wdata[5:0];
        default: exc_mask <= exc_mask;
      endcase
    end
  end

  // Native mode status output and register read data.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      native_mode <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      native_mode <= native_error_mode_bit;
      if (reg_rd) begin
        case (reg_addr)
          `FPEX_ADDR_CTRL: reg_rdata <= control_register_zero;
          `FPEX_ADDR_STATUS: reg_rdata <= {unmasked_pending, 1'b0, pend_flags};
          `FPEX_ADDR_MASK: reg_rdata <= {2'b00, exc_mask};
          `FPEX_ADDR_CAUSE: reg_rdata <= {6'h00, last_cause};
          `FPEX_ADDR_IMAGE: reg_rdata <= last_size[9:2];
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule

/* design/fpex_defines.vh */
// Constants for the floating-point exception signalling block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FPEX_DEFINES_VH
`define FPEX_DEFINES_VH
// Register offsets on the plain register port.
`define FPEX_ADDR_CTRL 4'h0
`define FPEX_ADDR_STATUS 4'h1
`define FPEX_ADDR_MASK 4'h2
`define FPEX_ADDR_CAUSE 4'h3
`define FPEX_ADDR_IMAGE 4'h4
// Control register zero fields.
`define FPEX_CTRL_TASKSW_BIT 3
`define FPEX_CTRL_NATIVE_BIT 5
`define FPEX_CTRL_RESET 8'h00
// Exception flags are six bits wide.
`define FPEX_FLAG_W 6
`define FPEX_MASK_RESET 6'h3F
// Operation codes on the instruction port.
`define FPEX_OP_ARITH 3'h0
`define FPEX_OP_WAIT 3'h1
`define FPEX_OP_NWSAVE 3'h2
`define FPEX_OP_SAVE 3'h3
`define FPEX_OP_RESTORE 3'h4
`define FPEX_OP_XSAVE 3'h5
`define FPEX_OP_XRESTORE 3'h6
`define FPEX_OP_NOWAIT 3'h7
// Outcome codes.
`define FPEX_RES_DONE 2'h0
`define FPEX_RES_UNAVAIL 2'h1
`define FPEX_RES_NUMERIC 2'h2
`define FPEX_RES_ALIGN 2'h3
// Vector numbers.
`define FPEX_VEC_UNAVAIL 8'h07
`define FPEX_VEC_NUMERIC 8'h10
`define FPEX_VEC_GP 8'h0D
// State image sizes in bytes.
`define FPEX_IMG_LEGACY16 10'h05E
`define FPEX_IMG_LEGACY32 10'h06C
`define FPEX_IMG_EXT 10'h200
`define FPEX_EXT_ALIGN_MASK 32'h0000000F
`endif

/* design/fpex_image_calc.v */
// Image size and alignment check for state save and restore operations.
// Assumes a byte address and operand size valid with the operation code.
`include "fpex_defines.vh"
module fpex_image_calc (
  input wire [2:0] op,
  input wire op32,
  input wire [31:0] addr,
  output reg [9:0] size,
  output reg misaligned,
  output reg is_legacy_img,
  output reg is_ext_img
);
  // Size selection and the alignment test for the extended image.
  always @* begin
    size = 10'h000;
    misaligned = 1'b0;
    is_legacy_img = 1'b0;
    is_ext_img = 1'b0;
    case (op)
      `FPEX_OP_NWSAVE, `FPEX_OP_SAVE, `FPEX_OP_RESTORE: begin
        size = op32 ? `FPEX_IMG_LEGACY32 : `FPEX_IMG_LEGACY16;
        is_legacy_img = 1'b1;
      end
      `FPEX_OP_XSAVE, `FPEX_OP_XRESTORE: begin
        size = `FPEX_IMG_EXT;
        is_ext_img = 1'b1;
        misaligned = |(addr & `FPEX_EXT_ALIGN_MASK);
      end
      default: begin
        size = 10'h000;
      end
    endcase
  end
endmodule

/* design/fpex_pending.v */
// Pending exception flag store: sets from the arithmetic unit, loads on restore.
// Assumes single-cycle strobes from the sequencer in the top module.
`include "fpex_defines.vh"
module fpex_pending (
  input wire core_clk,
  input wire rst_n,
  input wire [5:0] set_flags,
  input wire clear_all,
  input wire load_en,
  input wire [5:0] load_flags,
  input wire sw_clear_en,
  input wire [5:0] sw_clear,
  output reg [5:0] flags
);
  wire [5:0] next_flags;
  genvar i;
  // Per-bit next value: set beats a load, and a load beats any clear in the same cycle.
  generate
    for (i = 0; i < `FPEX_FLAG_W; i = i + 1) begin : g_flag
      assign next_flags[i] = set_flags[i] |
        (load_en ? load_flags[i] : (flags[i] & ~(clear_all | (sw_clear_en & sw_clear[i]))));
    end
  endgenerate

  // One register for all flags, so each bit has a single driver.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      flags <= 6'h00;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

/* tb/fpex_irq_model.sv */
// Interrupt controller model on the far side of the error output.
// Assumes the unit's clock; the delivery delay is a system choice.
module fpex_irq_model #(
  parameter int DLY = 3
) (
  input logic core_clk,
  input logic fpu_error_output,
  input logic native_mode,
  output logic legacy_fpu_irq_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dly_line = 8'h00;
  always @(posedge core_clk) begin
    dly_line <= {dly_line[6:0], fpu_error_output & ~native_mode};
  end
  // The request shows DLY cycles after the error output.
  assign legacy_fpu_irq_line = dly_line[DLY-1];
endmodule

/* tb/fpex_checker.sv */
// Checker for the exception unit's port behaviour.
// Assumes it is bound into the unit and sees only its ports.
module fpex_checker (
  input logic core_clk,
  input logic rst_n,
  input logic multi_proc,
  input logic op_valid,
  input logic [2:0] op,
  input logic [31:0] op_addr,
  input logic reg_wr,
  input logic fpu_error_output,
  input logic res_valid,
  input logic [1:0] res_code,
  input logic [7:0] res_vector,
  input logic native_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Outcomes carry their own vector numbers.
  a_unavail_vector: assert property (res_valid && res_code == 2'h1 |-> res_vector == 8'h07)
    else $error("bad fault vector");
  a_num_vector: assert property (res_valid && res_code == 2'h2 |-> res_vector == 8'h10)
    else $error("bad numeric vector");
  a_align_vector: assert property (res_valid && res_code == 2'h3 |-> res_vector == 8'h0D)
    else $error("bad alignment vector");
  // No-wait forms never take the numeric exception.
  a_nowait_no_num: assert property (op_valid && (op == 3'h2 || op == 3'h7) |=> res_code != 2'h2)
    else $error("no-wait op took numeric");
  // A misaligned extended image never completes.
  a_misalign_fault: assert property (op_valid && (op == 3'h5 || op == 3'h6) && op_addr[3:0] != 4'h0
    |=> res_valid && res_code != 2'h0)
    else $error("misaligned image accepted");
  // A no-wait save with a pending exception pulses the error output.
  a_save_pulse: assert property (op_valid && op == 3'h2 && fpu_error_output && !res_valid && !$past(reg_wr)
    |=> fpu_error_output)
    else $error("no error pulse on save");
  // Multiprocessor strapping forces native reporting.
  a_native_follow: assert property (multi_proc |=> native_mode)
    else $error("native mode not forced");
  // The error output holds while nothing can clear the flags.
  a_err_holds: assert property (fpu_error_output && !op_valid && !res_valid && !reg_wr && !$past(reg_wr)
    |=> fpu_error_output)
    else $error("error output dropped");
  // Main scenarios reached.
  c_unavail: cover property (res_valid && res_code == 2'h1);
  c_save_pend: cover property (op_valid && op == 3'h2 && fpu_error_output);
  c_native: cover property (native_mode && fpu_error_output);
endmodule
bind fpex_unit fpex_checker chk_i (.core_clk(core_clk), .rst_n(rst_n), .multi_proc(multi_proc),
  .op_valid(op_valid), .op(op), .op_addr(op_addr), .reg_wr(reg_wr), .fpu_error_output(fpu_error_output),
  .res_valid(res_valid), .res_code(res_code), .res_vector(res_vector), .native_mode(native_mode));

/* tb/tb.sv */
// Self-checking testbench for the exception unit and interrupt model.
// Assumes a 100 MHz clock and a synchronous active-low reset.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = '0, rst_n = '0, multi_proc = '0, op_valid = '0, op32 = '0, exc_valid = '0;
  logic reg_wr = '0, reg_rd = '0, fpu_error_output, res_valid, img_ext_format, fpu_reinit;
  logic native_mode, legacy_fpu_irq_line;
  logic [2:0] op = '0, o;
  logic [31:0] op_addr = '0, seed = 32'h420350EE;
  logic [5:0] exc_flags = '0, f;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, res_vector;
  logic [1:0] res_code;
  logic [9:0] img_size;
  int err_count = 0, n_compared = 0;
  fpex_unit dut (.core_clk(core_clk), .rst_n(rst_n), .multi_proc(multi_proc), .op_valid(op_valid), .op(op),
    .op32(op32), .op_addr(op_addr), .exc_flags(exc_flags), .exc_valid(exc_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fpu_error_output(fpu_error_output), .res_valid(res_valid), .res_code(res_code), .res_vector(res_vector),
    .img_size(img_size), .img_ext_format(img_ext_format), .fpu_reinit(fpu_reinit), .native_mode(native_mode));
  fpex_irq_model #(.DLY(3)) pic (.core_clk(core_clk), .fpu_error_output(fpu_error_output),
    .native_mode(native_mode), .legacy_fpu_irq_line(legacy_fpu_irq_line));
  // Free-running core clock.
  always #5 core_clk = ~core_clk;
  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Image size in bytes for a save or restore.
  function automatic logic [9:0] exp_size(input logic [2:0] c, input logic w);
    if (c > 3'h4) return 10'h200;
    return w ? 10'h06C : 10'h05E;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic exc(input logic [5:0] fl);
    @(posedge core_clk);
    exc_valid <= 1'h1;
    exc_flags <= fl;
    @(posedge core_clk);
    exc_valid <= 1'h0;
    #1;
  endtask
  task automatic doop(input logic [2:0] c, input logic w, input logic [31:0] a);
    @(posedge core_clk);
    op_valid <= 1'h1;
    op <= c;
    op32 <= w;
    op_addr <= a;
    @(posedge core_clk);
    op_valid <= 1'h0;
    #1;
  endtask
  task automatic res(input logic [1:0] c, input logic [7:0] v);
    chk({res_valid, res_code, res_vector}, {1'h1, c, v});
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far beyond the fewer than a hundred cycles used.
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
  // Main sequence of scenarios.
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    wr(4'hF, 8'hFF);
    rdchk(4'h0, 8'h00);
    rdchk(4'h2, 8'h3F);
    rdchk(4'h1, 8'h00);
    rdchk(4'hF, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      o = 3'h2 + 3'(i % 5);
      doop(o, i >= 5, rnd() & 32'hFFFFFFF0);
      chk({res_code, img_size}, {2'h0, exp_size(o, i >= 5)});
      chk({img_ext_format, fpu_reinit}, {o > 3'h4, o < 3'h4});
    end
    rdchk(4'h4, 8'h80);
    for (int j = 0; j < 2; j++) begin
      doop(3'h5 + 3'(j), 1'(j), rnd() | 32'h1);
      res(2'h3, 8'h0D);
    end
    $display("test images done");
    wr(4'h1, 8'h3F);
    wr(4'h2, 8'h00);
    f = 6'(rnd()) | 6'h01;
    exc(f);
    chk(fpu_error_output, 1'h1);
    rdchk(4'h1, {2'h2, f});
    doop(3'h7, 1'h0, 32'h0);
    res(2'h0, 8'h00);
    doop(3'h0, 1'h0, 32'h0);
    res(2'h2, 8'h10);
    wr(4'h0, 8'h08);
    doop(3'h0, 1'h1, 32'h0);
    res(2'h1, 8'h07);
    chk(fpu_error_output, 1'h1);
    doop(3'h1, 1'h1, 32'h0);
    res(2'h2, 8'h10);
    wr(4'h0, 8'h00);
    $display("test pending done");
    doop(3'h2, 1'h1, 32'h0);
    chk({res_code, fpu_reinit, fpu_error_output, legacy_fpu_irq_line}, {2'h0, 3'h7});
    @(posedge core_clk);
    #1 chk(fpu_error_output, 1'h0);
    doop(3'h4, 1'h0, {f, 26'h0});
    doop(3'h0, 1'h0, 32'h0);
    res(2'h2, 8'h10);
    rdchk(4'h3, 8'h02);
    wr(4'h1, 8'h3F);
    repeat (2) @(posedge core_clk);
    #1 chk(fpu_error_output, 1'h0);
    $display("test save restore done");
    @(posedge core_clk);
    multi_proc <= 1'h1;
    exc(f);
    doop(3'h2, 1'h0, 32'h0);
    res(2'h0, 8'h00);
    chk({fpu_error_output, native_mode, legacy_fpu_irq_line}, 3'h6);
    multi_proc <= 1'h0;
    wr(4'h0, 8'h20);
    exc(f);
    doop(3'h0, 1'h0, 32'h0);
    res(2'h2, 8'h10);
    chk(native_mode, 1'h1);
    $display("test native done");
    complete_run();
  end
endmodule
